// File: hdl/iepx_consts.svh
// Constants for the extended interrupt enable, priority and external input block.
// Assumes an 8-bit special-function register port with a page select from the core.
`ifndef IEPX_CONSTS_SVH
`define IEPX_CONSTS_SVH
`define IEPX_ADDR_EN2 8'ha5
`define IEPX_ADDR_PRI2L 8'ha6
`define IEPX_ADDR_PRI2H 8'ha7
`define IEPX_ADDR_EN1 8'had
`define IEPX_ADDR_PRI1L 8'hae
`define IEPX_ADDR_PRI1H 8'haf
`define IEPX_ADDR_PRI0H 8'hb7
`define IEPX_ADDR_PRI0L 8'hb8
`define IEPX_ADDR_XCFG 8'hc1
`define IEPX_PAGE_CFG0 4'h0
`define IEPX_PAGE_CFG1 4'h1
`define IEPX_RST_VAL 8'h00
`define IEPX_SEL_HI 7
`define IEPX_SEL_LO 4
`define IEPX_DIV_SIX 3'h5
`define IEPX_FLT_SAMPLES 2'h3
`define IEPX_NSRC 24
`define IEPX_SRC_SYSF 11
`endif

// File: hdl/iepx_filter.sv
// Three-sample glitch filter for one external interrupt input.
// Assumes the sample ticks are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`include "iepx_consts.svh"
module iepx_filter
  import iepx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire iepx_flt_t mode,
  input wire logic tick_div6,
  input wire logic timer3_overflow_tick,
  // Data
  input wire logic raw,
  output logic filt
);
  logic tick;
  logic [1:0] cnt_reg;
  logic held_reg;

  always_comb begin
    case (mode)
      IEPX_FLT_CLK: tick = 1'b1;
      IEPX_FLT_DIV6: tick = tick_div6;
      IEPX_FLT_T3: tick = timer3_overflow_tick;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      held_reg <= 1'b1;
      cnt_reg <= 2'h0;
    end else if (mode == IEPX_FLT_OFF) begin
      held_reg <= raw;
      cnt_reg <= 2'h0;
    end else if (raw == held_reg) begin
      cnt_reg <= 2'h0;
    end else if (tick) begin
      if (cnt_reg == `IEPX_FLT_SAMPLES - 2'h1) begin
        held_reg <= raw;
        cnt_reg <= 2'h0;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end

  assign filt = held_reg;

  filt_needs_three_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == IEPX_FLT_CLK && $past(mode) == IEPX_FLT_CLK && $changed(held_reg))
      |-> $past(raw, 1) == held_reg && $past(raw, 2) == held_reg && $past(raw, 3) == held_reg)
    else $error("filtered level changed without three samples");
endmodule

// File: hdl/iepx_pkg.sv
// Types for the extended interrupt enable and priority block.
// Assumes the constants header is included by the files that use it.
package iepx_pkg;
  typedef enum logic [1:0] {
    IEPX_FLT_OFF = 2'h0,
    IEPX_FLT_CLK = 2'h1,
    IEPX_FLT_DIV6 = 2'h2,
    IEPX_FLT_T3 = 2'h3
  } iepx_flt_t;
  typedef struct packed {
    logic [7:0] en2;
    logic [7:0] en1;
    logic [7:0] en0;
  } iepx_en_t;
  typedef struct packed {
    logic missing_clock_flag;
    logic rtc_overflow_flag;
    logic brownout_flag_b;
    logic brownout_flag_a;
    logic watchdog_overflow_flag;
    logic bus_start_seen;
    logic bus_stop_seen;
    logic timer_event_flag;
  } iepx_sysf_t;
  typedef enum logic [1:0] {
    IEPX_IDLE = 2'h0,
    IEPX_REQ = 2'h1,
    IEPX_SERV = 2'h3
  } iepx_state_t;
endpackage

// File: hdl/iepx_top.sv
// Extended interrupt enable, priority and external input configuration block.
// Assumes a single-cycle register port from the core and level peripheral flags.
`timescale 1ns/1ps
`include "iepx_consts.svh"
module iepx_top
  import iepx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Basic enables owned by the core
  input wire logic global_irq_gate,
  input wire logic [5:0] base_enables,
  input wire logic [1:0] ext_hi_enables,
  // Trigger control
  input wire logic ext2_trigger_type,
  input wire logic ext2_polarity_high,
  input wire logic ext2_clear,
  // Pins
  input wire logic [3:0] pins_int1,
  input wire logic [3:0] pins_int0,
  input wire logic [3:0] pins_int3,
  input wire logic [2:0] pins_int2,
  input wire logic timer3_overflow_tick,
  // Peripheral flags
  input wire logic [23:0] src_flags,
  input wire logic keypad_flag,
  input wire logic conversion_done_flag,
  input wire logic spi_transfer_flag,
  input wire iepx_sysf_t sysflags,
  input wire iepx_sysf_t sysflag_source_enables,
  // Core service handshake
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [4:0] irq_src,
  output logic [1:0] irq_level,
  output logic [3:0] ext_filtered,
  output logic ext2_request
);
  localparam int NSRC = `IEPX_NSRC;
  logic [7:0] en1_reg, en2_reg;
  logic [7:0] p0l_reg, p0h_reg, p1l_reg, p1h_reg, p2l_reg, p2h_reg;
  logic [7:0] cfg0_reg, cfg1_reg;
  logic [2:0] div_reg;
  logic tick6;
  logic [3:0] raw_sel, filt;
  logic ext2_prev_reg, ext2_flag_reg;
  logic [NSRC-1:0] flags, pend;
  iepx_en_t en;
  logic [23:0] plo, phi;
  logic [3:0] active_reg;
  logic [1:0] cur_level;
  logic have_active;
  iepx_state_t state_reg;
  logic [4:0] best_src;
  logic [1:0] best_lvl;
  logic best_ok;
  logic sysf_any;
  logic cfg_sel0, cfg_sel1;

  function automatic logic [1:0] lvl_of(input logic h, input logic l);
    lvl_of = {h, l};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and read-back.
  assign cfg_sel0 = sfr_addr == `IEPX_ADDR_XCFG && sfr_page == `IEPX_PAGE_CFG0;
  assign cfg_sel1 = sfr_addr == `IEPX_ADDR_XCFG && sfr_page == `IEPX_PAGE_CFG1;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en1_reg <= `IEPX_RST_VAL;
      en2_reg <= `IEPX_RST_VAL;
      p0l_reg <= `IEPX_RST_VAL;
      p0h_reg <= `IEPX_RST_VAL;
      p1l_reg <= `IEPX_RST_VAL;
      p1h_reg <= `IEPX_RST_VAL;
      p2l_reg <= `IEPX_RST_VAL;
      p2h_reg <= `IEPX_RST_VAL;
      cfg0_reg <= `IEPX_RST_VAL;
      cfg1_reg <= `IEPX_RST_VAL;
    end else if (sfr_wr) begin
      if (sfr_addr == `IEPX_ADDR_EN1) en1_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_EN2) en2_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI0L) p0l_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI0H) p0h_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI1L) p1l_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI1H) p1h_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI2L) p2l_reg <= sfr_wdata;
      if (sfr_addr == `IEPX_ADDR_PRI2H) p2h_reg <= sfr_wdata;
      if (cfg_sel0) cfg0_reg <= sfr_wdata;
      if (cfg_sel1) cfg1_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `IEPX_ADDR_EN1: sfr_rdata <= en1_reg;
        `IEPX_ADDR_EN2: sfr_rdata <= en2_reg;
        `IEPX_ADDR_PRI0L: sfr_rdata <= p0l_reg;
        `IEPX_ADDR_PRI0H: sfr_rdata <= p0h_reg;
        `IEPX_ADDR_PRI1L: sfr_rdata <= p1l_reg;
        `IEPX_ADDR_PRI1H: sfr_rdata <= p1h_reg;
        `IEPX_ADDR_PRI2L: sfr_rdata <= p2l_reg;
        `IEPX_ADDR_PRI2H: sfr_rdata <= p2h_reg;
        `IEPX_ADDR_XCFG: sfr_rdata <= cfg_sel0 ? cfg0_reg : (cfg_sel1 ? cfg1_reg : 8'h00);
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin selection and input filters.
  always_comb begin
    raw_sel[1] = pins_int1[cfg0_reg[`IEPX_SEL_HI -: 2]];
    raw_sel[0] = pins_int0[cfg0_reg[`IEPX_SEL_LO + 1 -: 2]];
    raw_sel[3] = pins_int3[cfg1_reg[`IEPX_SEL_HI -: 2]];
    case (cfg1_reg[`IEPX_SEL_LO + 1 -: 2])
      2'h0: raw_sel[2] = pins_int2[0];
      2'h1: raw_sel[2] = pins_int2[1];
      2'h2: raw_sel[2] = pins_int2[2];
      default: raw_sel[2] = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= (div_reg == `IEPX_DIV_SIX) ? 3'h0 : div_reg + 3'h1;
    end
  end
  assign tick6 = div_reg == `IEPX_DIV_SIX;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flt
      iepx_filter u_flt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode(iepx_flt_t'({cfg1_reg[gi], cfg0_reg[gi]})),
        .tick_div6(tick6),
        .timer3_overflow_tick(timer3_overflow_tick),
        .raw(raw_sel[gi]),
        .filt(filt[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext_filtered <= 4'hf;
    end else begin
      ext_filtered <= filt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External input 2 trigger; set wins over clear.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext2_prev_reg <= 1'b1;
      ext2_flag_reg <= 1'b0;
    end else begin
      ext2_prev_reg <= filt[2];
      if (!ext2_trigger_type) begin
        ext2_flag_reg <= filt[2] == ext2_polarity_high;
      end else if (ext2_prev_reg != filt[2] && filt[2] == ext2_polarity_high) begin
        ext2_flag_reg <= 1'b1;
      end else if (ext2_clear) begin
        ext2_flag_reg <= 1'b0;
      end
    end
  end
  assign ext2_request = ext2_flag_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Request gating and priority arbitration.
  assign sysf_any = |(sysflags & sysflag_source_enables);
  always_comb begin
    flags = src_flags;
    flags[13] = keypad_flag;
    flags[9] = conversion_done_flag;
    flags[8] = spi_transfer_flag;
    flags[`IEPX_SRC_SYSF] = sysf_any;
    flags[6] = ext2_flag_reg;
  end
  assign en.en0 = {ext_hi_enables, base_enables};
  assign en.en1 = en1_reg;
  assign en.en2 = en2_reg;
  assign plo = {p2l_reg, p1l_reg, p0l_reg};
  assign phi = {p2h_reg, p1h_reg, p0h_reg};
  assign pend = flags & en & {NSRC{global_irq_gate}};

  always_comb begin
    best_ok = 1'b0;
    best_src = 5'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && (!best_ok || lvl_of(phi[i], plo[i]) > best_lvl)) begin
        best_ok = 1'b1;
        best_src = 5'(i);
        best_lvl = lvl_of(phi[i], plo[i]);
      end
    end
    cur_level = 2'h0;
    have_active = |active_reg;
    for (int k = 0; k < 4; k++) begin
      if (active_reg[k]) cur_level = 2'(k);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IEPX_IDLE;
      irq_req <= 1'b0;
      irq_src <= 5'h0;
      irq_level <= 2'h0;
      active_reg <= 4'h0;
    end else begin
      if (irq_return && have_active) active_reg[cur_level] <= 1'b0;
      case (state_reg)
        IEPX_IDLE: begin
          if (best_ok && (!have_active || best_lvl > cur_level)) begin
            irq_req <= 1'b1;
            irq_src <= best_src;
            irq_level <= best_lvl;
            state_reg <= IEPX_REQ;
          end
        end
        IEPX_REQ: begin
          if (irq_ack) begin
            irq_req <= 1'b0;
            active_reg[irq_level] <= 1'b1;
            state_reg <= IEPX_SERV;
          end else if (!best_ok) begin
            irq_req <= 1'b0;
            state_reg <= IEPX_IDLE;
          end
        end
        IEPX_SERV: state_reg <= IEPX_IDLE;
        default: state_reg <= IEPX_IDLE;
      endcase
    end
  end

  sequence req_raised_s;
    $rose(irq_req);
  endsequence

  sequence ack_taken_s;
    irq_req && irq_ack;
  endsequence

  no_gate_req_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_raised_s |-> $past(global_irq_gate)) else $error("request raised with global gate off");
  req_enabled_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_raised_s |-> |($past(pend) & (NSRC'(1) << irq_src)))
    else $error("request for a source not pending");
  no_preempt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_raised_s |-> !$past(have_active) || irq_level > $past(cur_level))
    else $error("request at equal or lower level than service");
  level_pair_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    req_raised_s |-> irq_level == {|($past(phi) & (NSRC'(1) << irq_src)),
      |($past(plo) & (NSRC'(1) << irq_src))})
    else $error("level mismatch");
  en1_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && sfr_addr == `IEPX_ADDR_EN1 |=> en1_reg == $past(sfr_wdata)) else $error("enable one not written");
  cfg_page_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && cfg_sel1 |=> $stable(cfg0_reg)) else $error("page 1 write hit config 0");
  sysf_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(irq_req) && irq_src == 5'(`IEPX_SRC_SYSF)
      |-> $past(|(sysflags & sysflag_source_enables)) && $past(en1_reg[3]))
    else $error("sysflag request without an enabled flag");
  edge_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ext2_trigger_type && $past(ext2_trigger_type) && $rose(ext2_flag_reg)
      |-> $past(filt[2]) == $past(ext2_polarity_high) && $past(filt[2], 2) != $past(filt[2]))
    else $error("edge flag without edge");
  ack_starts_serv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ack_taken_s |=> !irq_req && active_reg[$past(irq_level)]) else $error("acknowledge did not start service");
  return_ends_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_return && have_active && !irq_ack |=> !active_reg[$past(cur_level)])
    else $error("return did not end the current level");
  cfg0_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && cfg_sel0 |=> cfg0_reg == $past(sfr_wdata)) else $error("page 0 write missed config 0");
  en2_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && sfr_addr == `IEPX_ADDR_EN2 |=> en2_reg == $past(sfr_wdata)) else $error("enable two not written");
  pri0_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && sfr_addr == `IEPX_ADDR_PRI0L |=> p0l_reg == $past(sfr_wdata))
    else $error("priority zero low not written");
  pri2_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_wr && sfr_addr == `IEPX_ADDR_PRI2H |=> p2h_reg == $past(sfr_wdata))
    else $error("priority two high not written");
  div_tick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick6 |=> (!tick6) [*5] ##1 tick6) else $error("divide by six tick out of step");
endmodule

// File: verif/iepx_core_model.sv
// Core-side partner model: accepts requests and serves each one.
// Assumes the request handshake of the block on clk_sys.
`timescale 1ns/1ps
module iepx_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Service handshake
  input wire logic irq_req,
  output logic irq_ack,
  output logic irq_return
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////
  // Accepts two cycles after a request and ends service six cycles later.
  always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt = 0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (cnt > 0 || irq_req === 1'b1) begin
        cnt = cnt + 1;
      end
      if (cnt == 2) begin
        irq_ack <= 1'b1;
      end
      if (cnt == 8) begin
        irq_return <= 1'b1;
        cnt = 0;
      end
    end
  end
endmodule

// File: verif/tb.sv
// Self-checking bench for the interrupt enable, priority and pin block.
// Assumes the core model answers requests; inputs change at falling edges.
`timescale 1ns/1ps
module tb
  import iepx_pkg::*;
;
  typedef struct {logic [7:0] a; logic [3:0] p; logic [7:0] d;} iepx_row_t;
  logic clk_sys, nrst, sfr_wr, sfr_rd, global_irq_gate, ext2_trigger_type, ext2_polarity_high;
  logic ext2_clear, timer3_overflow_tick, keypad_flag, conversion_done_flag, spi_transfer_flag;
  logic irq_ack, irq_return, irq_req, ext2_request;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic [3:0] sfr_page, pins_int1, pins_int0, pins_int3, ext_filtered;
  logic [5:0] base_enables;
  logic [1:0] ext_hi_enables, irq_level;
  logic [2:0] pins_int2;
  logic [23:0] src_flags;
  logic [4:0] irq_src;
  iepx_sysf_t sysflags, sysflag_source_enables;
  int failures, checks_done, c, m, n, g, b, t3cnt = 0;
  int per[4] = '{0, 1, 6, 4};
  int srcs[8] = '{8, 9, 13, 11, 16, 23, 3, 7};
  logic [7:0] pri_h[3] = '{8'hb7, 8'haf, 8'ha7};
  logic [7:0] pri_l[3] = '{8'hb8, 8'hae, 8'ha6};
  logic [7:0] en_a[3] = '{8'h00, 8'had, 8'ha5};
  iepx_row_t regs[11] = '{'{8'ha5, 4'h0, 8'h11}, '{8'ha6, 4'h0, 8'h22}, '{8'ha7, 4'h0, 8'h33},
    '{8'had, 4'h0, 8'h44}, '{8'hae, 4'h0, 8'h55}, '{8'haf, 4'h0, 8'h66}, '{8'hb7, 4'h0, 8'h77},
    '{8'hb8, 4'h0, 8'h88}, '{8'hc1, 4'h0, 8'h99}, '{8'hc1, 4'h1, 8'haa}, '{8'hb0, 4'h0, 8'h00}};

  iepx_top iepx_top_inst (.clk_sys, .nrst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_page, .sfr_wdata, .sfr_rdata,
    .global_irq_gate, .base_enables, .ext_hi_enables, .ext2_trigger_type, .ext2_polarity_high, .ext2_clear,
    .pins_int1, .pins_int0, .pins_int3, .pins_int2, .timer3_overflow_tick, .src_flags, .keypad_flag,
    .conversion_done_flag, .spi_transfer_flag, .sysflags, .sysflag_source_enables, .irq_ack, .irq_return,
    .irq_req, .irq_src, .irq_level, .ext_filtered, .ext2_request);
  iepx_core_model iepx_core_model_inst (.clk_sys, .nrst, .irq_req, .irq_ack, .irq_return);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    t3cnt <= (t3cnt + 1) % 4;
    timer3_overflow_tick <= (t3cnt == 0);
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [3:0] p, logic [7:0] d);
    @(negedge clk_sys);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_page = p;
    sfr_wdata = d;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [3:0] p);
    @(negedge clk_sys);
    sfr_rd = 1'b1;
    sfr_addr = a;
    sfr_page = p;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    {sfr_wr, sfr_rd, sfr_addr, sfr_page, sfr_wdata} = '0;
    {global_irq_gate, base_enables, ext_hi_enables, ext2_trigger_type, ext2_polarity_high, ext2_clear} = '0;
    {pins_int1, pins_int0, pins_int3, pins_int2} = '1;
    {src_flags, keypad_flag, conversion_done_flag, spi_transfer_flag, sysflags, sysflag_source_enables} = '0;
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
  endtask
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic quiet(int k);
    repeat (k) begin
      @(negedge clk_sys);
      chk("irq_req idle", 8'h0, {7'h0, irq_req});
    end
  endtask
  task automatic want(logic [4:0] s, logic [1:0] l);
    for (int i = 0; i < 10 && irq_req !== 1'b1; i++) @(negedge clk_sys);
    chk("irq_req", 8'h1, {7'h0, irq_req});
    chk("irq_src", {3'h0, s}, {3'h0, irq_src});
    chk("irq_level", {6'h0, l}, {6'h0, irq_level});
  endtask
  task automatic raise(int s, logic on);
    case (s)
      8: spi_transfer_flag = on;
      9: conversion_done_flag = on;
      13: keypad_flag = on;
      11: begin
        sysflags.timer_event_flag = on;
        sysflag_source_enables.timer_event_flag = on;
      end
      default: src_flags[s] = on;
    endcase
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    foreach (regs[i]) begin
      rd(regs[i].a, regs[i].p);
      chk("reset value", 8'h00, v);
    end
    foreach (regs[i]) wr(regs[i].a, regs[i].p, regs[i].d);
    wr(8'hc1, 4'h2, 8'hff);
    foreach (regs[i]) begin
      rd(regs[i].a, regs[i].p);
      chk("register", regs[i].d, v);
    end
    foreach (srcs[k]) begin
      do_reset();
      g = srcs[k] / 8;
      b = srcs[k] % 8;
      global_irq_gate = 1'b1;
      raise(srcs[k], 1'b1);
      quiet(4);
      global_irq_gate = 1'b0;
      wr(pri_h[g], 4'h0, {7'h0, k[1]} << b);
      wr(pri_l[g], 4'h0, {7'h0, k[0]} << b);
      if (g == 0) {ext_hi_enables, base_enables} = 8'h01 << b;
      else wr(en_a[g], 4'h0, 8'h01 << b);
      quiet(4);
      global_irq_gate = 1'b1;
      want(srcs[k][4:0], k[1:0]);
      raise(srcs[k], 1'b0);
    end
    do_reset();
    global_irq_gate = 1'b1;
    wr(8'had, 4'h0, 8'h08);
    sysflags.watchdog_overflow_flag = 1'b1;
    quiet(4);
    sysflag_source_enables.watchdog_overflow_flag = 1'b1;
    want(5'd11, 2'h0);
    do_reset();
    global_irq_gate = 1'b1;
    wr(8'haf, 4'h0, 8'h02);
    wr(8'had, 4'h0, 8'h03);
    spi_transfer_flag = 1'b1;
    conversion_done_flag = 1'b1;
    want(5'd9, 2'h2);
    repeat (3) @(negedge clk_sys);
    conversion_done_flag = 1'b0;
    quiet(3);
    want(5'd8, 2'h0);
    do_reset();
    for (c = 0; c < 4; c++) begin
      wr(8'hc1, 4'h0, {c[1:0], c[1:0], 4'h0});
      wr(8'hc1, 4'h1, {c[1:0], c[1:0], 4'h0});
      {pins_int0, pins_int1, pins_int3, pins_int2} = {~(4'h1 << c), ~(4'h1 << c), ~(4'h1 << c), ~(3'h1 << c)};
      settle();
      chk("selected pins low", {5'h0, c == 3, 2'h0}, {4'h0, ext_filtered});
      {pins_int0, pins_int1, pins_int3, pins_int2} = ~{pins_int0, pins_int1, pins_int3, pins_int2};
      settle();
      chk("selected pins high", 8'h0f, {4'h0, ext_filtered});
    end
    for (m = 0; m < 4; m++) begin
      do_reset();
      {ext2_trigger_type, ext2_polarity_high} = m[1:0];
      pins_int2[0] = ~m[0];
      settle();
      ext2_clear = 1'b1;
      @(negedge clk_sys);
      ext2_clear = 1'b0;
      settle();
      chk("ext2 idle", 8'h0, {7'h0, ext2_request});
      pins_int2[0] = m[0];
      settle();
      chk("ext2 active", 8'h1, {7'h0, ext2_request});
      pins_int2[0] = ~m[0];
      settle();
      chk("ext2 after release", {7'h0, m[1]}, {7'h0, ext2_request});
      ext2_clear = 1'b1;
      settle();
      ext2_clear = 1'b0;
      chk("ext2 cleared", 8'h0, {7'h0, ext2_request});
    end
    for (m = 1; m < 4; m++) begin
      do_reset();
      wr(8'hc1, 4'h0, {7'h0, m[0]});
      wr(8'hc1, 4'h1, {7'h0, m[1]});
      pins_int0[0] = 1'b0;
      repeat (per[m] + 1) @(negedge clk_sys);
      pins_int0[0] = 1'b1;
      repeat (3 * per[m] + 4) @(negedge clk_sys);
      chk("glitch filtered", 8'h1, {7'h0, ext_filtered[0]});
      pins_int0[0] = 1'b0;
      n = 0;
      while (ext_filtered[0] !== 1'b0 && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      chk("filter delay", 8'h1, {7'h0, n >= 2 * per[m] + 1 && n <= 3 * per[m] + 4});
    end
    stop_test();
  end
endmodule
